// file: cfa_regs.svh
// register offsets, field positions, reset values and the default address width for the field-policy block
`ifndef CFA_REGS_SVH
`define CFA_REGS_SVH
`define CFA_ADDR_CTRL 32'h0000_0000
`define CFA_ADDR_STAT 32'h0000_0004
`define CFA_ADDR_MODE 32'h0000_0008
`define CFA_CTRL_RESET 32'h0000_0000
`define CFA_STAT_RESET 32'h0000_0000
`define CFA_MODE_RESET 32'h0000_0000
`define CFA_MODE_SEL_BIT 0
`define CFA_MODE_FR_BIT 1
`define CFA_PA_WIDTH_DEFAULT 36
`endif

// file: cfa_pkg.sv
// types for the field-policy block
package cfa_pkg;
  typedef enum logic [5:0] {
    CFA_RW = 6'h01,
    CFA_RO_HW = 6'h02,
    CFA_RSVD = 6'h04,
    CFA_LEG_CUR = 6'h08,
    CFA_LEG_OLD = 6'h10,
    CFA_W0C = 6'h20
  } cfa_policy_t;
  typedef enum logic [2:0] {
    CFA_ST_ADDR = 3'h1,
    CFA_ST_WR = 3'h2,
    CFA_ST_RD = 3'h4
  } cfa_state_t;
endpackage : cfa_pkg

// file: cfa_csr_field.sv
// access-policy field bank and the architectural state bits, with an ahb-lite slave
`timescale 1ns/100ps
`include "cfa_regs.svh"

module cfa_csr_field #(
  parameter int PA_WIDTH = `CFA_PA_WIDTH_DEFAULT,
  parameter logic [31:0] CTRL_POLICY_RW = 32'h0000_00FF,
  parameter logic [31:0] STAT_POLICY_HW = 32'h0000_FF00,
  parameter logic [31:0] STAT_POLICY_W0C = 32'h00FF_0000,
  parameter logic [31:0] STAT_POLICY_LEG = 32'hFF00_0000,
  parameter logic [31:0] STAT_PRESET = 32'h0000_0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] hw_ctrl_we,
  input wire logic [7:0] hw_ctrl_val,
  input wire logic [7:0] hw_stat_we,
  input wire logic [7:0] hw_stat_val,
  input wire logic [7:0] hw_w0c_set,
  input wire logic [7:0] hw_w0c_clr,
  input wire logic hw_mode_we,
  input wire logic hw_mode_sel,
  input wire logic [31:0] cur_pc,
  input wire logic in_delay_slot,
  input wire logic branch_retired,
  output logic [7:0] ctrl_out,
  output logic [7:0] w0c_out,
  output logic decode_set_selector,
  output logic decode_compressed,
  output logic decode_fixed32,
  output logic fpu_reg_width_mode,
  output logic [31:0] link_addr,
  output logic delay_slot_indicator,
  output logic [7:0] phys_addr_width
);
  // ==========================================================
  // bus slave
  cfa_pkg::cfa_state_t state;
  logic [31:0] addr_q;
  logic [31:0] field_q;
  logic fpu_width_status_bit;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mode;
  logic [31:0] rd_mux;
  logic [31:0] stat_view;

  assign hresp = 1'b0;
  assign wr_ctrl = (state == cfa_pkg::CFA_ST_WR) && (addr_q == `CFA_ADDR_CTRL);
  assign wr_stat = (state == cfa_pkg::CFA_ST_WR) && (addr_q == `CFA_ADDR_STAT);
  assign wr_mode = (state == cfa_pkg::CFA_ST_WR) && (addr_q == `CFA_ADDR_MODE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= cfa_pkg::CFA_ST_ADDR;
      addr_q <= 32'h0000_0000;
      hreadyout <= 1'b1;
    end else begin
      unique case (state)
        cfa_pkg::CFA_ST_ADDR: begin
          if (hsel && htrans[1] && hreadyout) begin
            addr_q <= {haddr[31:2], 2'b00};
            state <= hwrite ? cfa_pkg::CFA_ST_WR : cfa_pkg::CFA_ST_RD;
          end
        end
        cfa_pkg::CFA_ST_WR: begin
          state <= cfa_pkg::CFA_ST_ADDR;
        end
        cfa_pkg::CFA_ST_RD: begin
          state <= cfa_pkg::CFA_ST_ADDR;
        end
      endcase
    end
  end

  // ==========================================================
  // field bank, one policy per bit chosen at elaboration
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_field
      localparam cfa_pkg::cfa_policy_t POL =
        (gi < 8) ? (CTRL_POLICY_RW[gi] ? cfa_pkg::CFA_RW : cfa_pkg::CFA_RSVD) :
        STAT_POLICY_HW[gi] ? cfa_pkg::CFA_RO_HW :
        STAT_POLICY_W0C[gi] ? cfa_pkg::CFA_W0C :
        STAT_POLICY_LEG[gi] ? cfa_pkg::CFA_LEG_OLD : cfa_pkg::CFA_RSVD;
      if (POL == cfa_pkg::CFA_RW) begin : g_rw
        logic bit_q;
        assign field_q[gi] = bit_q;
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            bit_q <= 1'b0;
          end else if (hw_ctrl_we[gi % 8]) begin
            bit_q <= hw_ctrl_val[gi % 8];
          end else if (wr_ctrl) begin
            bit_q <= hwdata[gi];
          end
        end
      end else if (POL == cfa_pkg::CFA_RO_HW) begin : g_hw
        logic bit_q;
        assign field_q[gi] = bit_q;
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            bit_q <= STAT_PRESET[gi];
          end else if (hw_stat_we[gi % 8]) begin
            bit_q <= hw_stat_val[gi % 8];
          end
        end
      end else if (POL == cfa_pkg::CFA_W0C) begin : g_w0c
        logic bit_q;
        assign field_q[gi] = bit_q;
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            bit_q <= 1'b0;
          end else if (hw_w0c_set[gi % 8]) begin
            bit_q <= 1'b1;
          end else if (hw_w0c_clr[gi % 8] || (wr_stat && !hwdata[gi])) begin
            bit_q <= 1'b0;
          end
        end
      end else begin : g_zero
        assign field_q[gi] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // architectural state bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      decode_set_selector <= 1'b0;
      fpu_width_status_bit <= 1'b0;
    end else begin
      if (hw_mode_we) begin
        decode_set_selector <= hw_mode_sel;
      end
      if (wr_mode) begin
        fpu_width_status_bit <= hwdata[`CFA_MODE_FR_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      decode_compressed <= 1'b0;
      decode_fixed32 <= 1'b1;
      fpu_reg_width_mode <= 1'b0;
      link_addr <= 32'h0000_0000;
      delay_slot_indicator <= 1'b0;
      phys_addr_width <= 8'h00;
      ctrl_out <= 8'h00;
      w0c_out <= 8'h00;
    end else begin
      decode_compressed <= decode_set_selector;
      decode_fixed32 <= !decode_set_selector;
      fpu_reg_width_mode <= fpu_width_status_bit;
      link_addr <= {cur_pc[31:1], decode_set_selector};
      delay_slot_indicator <= in_delay_slot && branch_retired;
      phys_addr_width <= 8'(PA_WIDTH);
      ctrl_out <= field_q[7:0];
      w0c_out <= field_q[23:16];
    end
  end

  // ==========================================================
  // read data
  assign stat_view = field_q;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if ({haddr[31:2], 2'b00} == `CFA_ADDR_CTRL) begin
      rd_mux = {24'h00_0000, field_q[7:0]};
    end else if ({haddr[31:2], 2'b00} == `CFA_ADDR_STAT) begin
      rd_mux = {stat_view[31:8], 8'h00};
    end else if ({haddr[31:2], 2'b00} == `CFA_ADDR_MODE) begin
      rd_mux = {30'h0000_0000, fpu_width_status_bit, 1'b0};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state == cfa_pkg::CFA_ST_ADDR && hsel && htrans[1] && !hwrite) begin
      // read data is registered at the end of the address phase
      hrdata <= rd_mux;
    end
  end
endmodule : cfa_csr_field

// file: cfa_monitor.sv
// assertion checker for the field-policy block
`timescale 1ns/100ps
module cfa_mon #(
  parameter int PA_WIDTH = 36
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] hw_ctrl_we,
  input wire logic [7:0] hw_ctrl_val,
  input wire logic [7:0] hw_w0c_set,
  input wire logic [7:0] hw_w0c_clr,
  input wire logic [31:0] cur_pc,
  input wire logic in_delay_slot,
  input wire logic branch_retired,
  input wire logic [7:0] ctrl_out,
  input wire logic [7:0] w0c_out,
  input wire logic decode_compressed,
  input wire logic decode_fixed32,
  input wire logic fpu_reg_width_mode,
  input wire logic [31:0] link_addr,
  input wire logic delay_slot_indicator,
  input wire logic [7:0] phys_addr_width
);
  wire logic acc = hsel && htrans[1];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ctrl_write: assert property (acc && hwrite && haddr == 32'h0 |=>
    ##2 ($past(|hw_ctrl_we, 2) || ctrl_out == $past(hwdata[7:0], 2))) else $error("ctrl write lost");
  chk_ctrl_hwupd: assert property (|hw_ctrl_we |=>
    ##1 ((ctrl_out & $past(hw_ctrl_we, 2)) == $past(hw_ctrl_val & hw_ctrl_we, 2)))
    else $error("ctrl hw lost");
  chk_w0c_clear: assert property (acc && hwrite && haddr == 32'h4 ##1 !(|hw_w0c_set || |hw_w0c_clr)
    |=> ##1 w0c_out == ($past(w0c_out) & $past(hwdata[23:16], 2))) else $error("w0c write wrong");
  chk_fpu_follow: assert property (acc && hwrite && haddr == 32'h8 |=>
    ##2 fpu_reg_width_mode == $past(hwdata[1], 2)) else $error("fpu width mode wrong");
  chk_rsvd_zero: assert property (acc && !hwrite && haddr == 32'h0 |->
    ##2 hrdata[31:8] == 24'h0) else $error("reserved bits read nonzero");
  chk_sel_hidden: assert property (acc && !hwrite && haddr == 32'h8 |->
    ##2 !hrdata[0]) else $error("selector visible in mode read");
  chk_decode_excl: assert property (decode_compressed != decode_fixed32)
    else $error("decode modes not exclusive");
  chk_link_merge: assert property ($past(hresetn) |->
    link_addr[31:1] == $past(cur_pc[31:1])) else $error("link address wrong");
  chk_slot_dyn: assert property ($past(hresetn) |->
    delay_slot_indicator == $past(in_delay_slot && branch_retired)) else $error("delay slot wrong");
  chk_pa_width: assert property ($past(hresetn) |->
    phys_addr_width == 8'(PA_WIDTH)) else $error("address width wrong");
  cover property (acc && hwrite && haddr == 32'h4);
  cover property (decode_compressed);
  cover property (delay_slot_indicator);
endmodule : cfa_mon

// file: cfa_csr_field_tb_top.sv
// self-checking bench for the field-policy block
`timescale 1ns/100ps
module cfa_csr_field_tb_top;
  localparam int PA = 40;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hw_mode_we = 0, hw_mode_sel = 0;
  logic in_delay_slot = 0, branch_retired = 0, hreadyout, hresp, decode_set_selector;
  logic decode_compressed, decode_fixed32, fpu_reg_width_mode, delay_slot_indicator;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, cur_pc = 0, hrdata, link_addr, rd, d;
  logic [7:0] hw_ctrl_we = 0, hw_ctrl_val = 0, hw_stat_we = 0, hw_stat_val = 0, v, w0c_model;
  logic [7:0] hw_w0c_set = 0, hw_w0c_clr = 0, ctrl_out, w0c_out, phys_addr_width;
  int failures = 0, samples_checked = 0, cycles = 0;
  cfa_csr_field #(.PA_WIDTH(PA)) i_cfa_csr_field (.*);
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end
  always @(posedge hclk) if (hresetn) begin
    cur_pc <= $urandom;
    {in_delay_slot, branch_retired} <= 2'($urandom);
  end
  function automatic logic [7:0] w0c_exp(logic [7:0] old, logic [7:0] s, logic [7:0] m);
    return (old | s) & m;
  endfunction : w0c_exp
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(32'h437C8BA8));
    w0c_model = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({ctrl_out, w0c_out, 7'h0, decode_fixed32, 8'h0}, 32'h0000_0100);
    xfer(32'h4, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      v = $urandom;
      xfer(32'h0, 1'b1, d);
      xfer(32'h0, 1'b0, 32'h0);
      chk(rd, {24'h0, d[7:0]});
      {hw_ctrl_we, hw_ctrl_val, hw_stat_we, hw_stat_val, hw_w0c_set} <= {8'hFF, ~v, 8'hFF, v, d[31:24]};
      @(posedge hclk);
      {hw_ctrl_we, hw_stat_we, hw_w0c_set} <= 24'h0;
      repeat (2) @(posedge hclk);
      chk({24'h0, ctrl_out}, {24'h0, ~v});
      xfer(32'h4, 1'b1, {8'h0, ~v, d[23:16], 8'h0});
      w0c_model = w0c_exp(w0c_model, d[31:24], ~v);
      xfer(32'h4, 1'b0, 32'h0);
      chk(rd & 32'hFFFF_FF00, {8'h0, w0c_model, v, 8'h0});
    end
    xfer(32'h10, 1'b1, d);
    xfer(32'h10, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      {hw_mode_we, hw_mode_sel} <= {1'b1, i[0]};
      @(posedge hclk);
      hw_mode_we <= 1'b0;
      xfer(32'h8, 1'b1, {30'h0, i[1], 1'b0});
      xfer(32'h8, 1'b0, 32'h0);
      chk(rd, {30'h0, i[1], 1'b0});
      chk({28'h0, link_addr[0], decode_compressed, decode_fixed32, fpu_reg_width_mode},
        {28'h0, i[0], i[0], !i[0], i[1]});
    end
    chk({24'h0, phys_addr_width}, PA);
    complete_run();
  end
endmodule : cfa_csr_field_tb_top
bind cfa_csr_field cfa_mon #(.PA_WIDTH(PA_WIDTH)) i_cfa_mon (.*);
